// ==== src/ssp_map.vh ====
`ifndef SSP_MAP_VH
`define SSP_MAP_VH
`define SSP_ADDR_STATUS   4'h0
`define SSP_ADDR_CTRL1    4'h4
`define SSP_ADDR_CTRL2    4'h8
`define SSP_ADDR_BUFFER   4'hc
`define SSP_ADDR_FLAGS    5'h10
`define SSP_RESET_BYTE    8'h00
`define SSP_BIT_SMP       7
`define SSP_BIT_CKE       6
`define SSP_BIT_HALT      4
`define SSP_BIT_BF        0
`define SSP_BIT_WRITE_COLLISION      7
`define SSP_BIT_OVF       6
`define SSP_BIT_EN        5
`define SSP_BIT_CKP       4
`define SSP_BIT_IF        0
`define SSP_MODE_DIV4     4'h0
`define SSP_MODE_DIV16    4'h1
`define SSP_MODE_DIV64    4'h2
`define SSP_MODE_TMR      4'h3
`define SSP_MODE_SLV_SS   4'h4
`define SSP_MODE_SLV      4'h5
`define SSP_HALF_DIV4     6'h01
`define SSP_HALF_DIV16    6'h07
`define SSP_HALF_DIV64    6'h1f
`define SSP_BITS          4'h8
`define SSP_RESP_OKAY     2'h0
`define SSP_RESP_SLVERR   2'h2
`endif

// ==== src/ssp_sync.v ====
`timescale 1ns/1ps
// Two-flop synchroniser for pins coming from the far party
module ssp_sync (
  input  wire aclk,
  input  wire aresetn,
  input  wire din,
  output reg  dout
);
  reg meta_q;
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b0;
      dout   <= 1'b0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule

// ==== src/ssp_spi.v ====
`timescale 1ns/1ps
`include "ssp_map.vh"
// One instance is one port with its own registers and pins
module ssp_spi (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        timer_tick,
  input  wire        sclk_in,
  output reg         sclk_out,
  output reg         sclk_oe,
  input  wire        sdi_in,
  output reg         sdo_out,
  output reg         sdo_oe,
  input  wire        ss_n_in
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] stat_q;
  reg [7:0] ctrl1_q;
  reg [7:0] ctrl2_q;
  reg [7:0] buf_q;
  reg [7:0] sr_q;
  reg       if_q;
  reg       busy_q;
  reg [3:0] cnt_q;
  reg [5:0] div_q;
  reg       phase_q;
  reg       sclk_q;
  reg       samp_q;
  reg       sin_q;
  reg       sck_prev_q;
  reg       tmr_prev_q;
  reg [4:0] aw_q;
  reg       aw_have_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q;
  reg       w_have_q;

  wire       en     = ctrl1_q[`SSP_BIT_EN];
  wire       clock_idle_level    = ctrl1_q[`SSP_BIT_CKP];
  wire       cke    = stat_q[`SSP_BIT_CKE];
  wire       input_sample_late    = stat_q[`SSP_BIT_SMP];
  wire [3:0] mode   = ctrl1_q[3:0];
  wire       master = (mode == `SSP_MODE_DIV4) || (mode == `SSP_MODE_DIV16) ||
                      (mode == `SSP_MODE_DIV64) || (mode == `SSP_MODE_TMR);
  wire       slave  = (mode == `SSP_MODE_SLV_SS) || (mode == `SSP_MODE_SLV);

  function [5:0] half_period;
    input [3:0] m;
    begin
      case (m)
        `SSP_MODE_DIV16: half_period = `SSP_HALF_DIV16;
        `SSP_MODE_DIV64: half_period = `SSP_HALF_DIV64;
        default:         half_period = `SSP_HALF_DIV4;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  wire sck_s;
  wire sdi_s;
  wire ss_n_s;
  ssp_sync u_sck (.aclk(aclk), .aresetn(aresetn), .din(sclk_in), .dout(sck_s));
  ssp_sync u_sdi (.aclk(aclk), .aresetn(aresetn), .din(sdi_in),  .dout(sdi_s));
  ssp_sync u_ss  (.aclk(aclk), .aresetn(aresetn), .din(ss_n_in), .dout(ss_n_s));

  // Slave select gates transfers only in the select-pin mode
  wire ss_ok     = (mode != `SSP_MODE_SLV_SS) || !ss_n_s;
  wire sck_edge  = slave && en && ss_ok && (sck_s != sck_prev_q);
  wire sck_act   = (sck_s != clock_idle_level);
  // Leading edge idle->active, trailing active->idle
  wire s_lead    = sck_edge && sck_act;
  wire s_trail   = sck_edge && !sck_act;
  wire s_shift   = cke ? s_trail : s_lead;
  wire s_sample  = cke ? s_lead  : s_trail;

  wire tmr_rise  = timer_tick && !tmr_prev_q;
  wire m_tick    = (mode == `SSP_MODE_TMR) ? tmr_rise : (div_q == 6'h00);

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite front end
  wire       wr_go  = aw_have_q && w_have_q && !s_axi_bvalid;
  wire       rd_go  = s_axi_arvalid && s_axi_arready;
  wire [4:0] raddr  = s_axi_araddr;
  wire       wr_buf = wr_go && (aw_q == {1'b0, `SSP_ADDR_BUFFER}) && ws_q[0];
  wire       rd_buf = rd_go && (raddr == {1'b0, `SSP_ADDR_BUFFER});
  wire       wr_ok  = (aw_q == {1'b0, `SSP_ADDR_STATUS}) || (aw_q == {1'b0, `SSP_ADDR_CTRL1}) ||
                      (aw_q == {1'b0, `SSP_ADDR_CTRL2}) || (aw_q == {1'b0, `SSP_ADDR_BUFFER}) ||
                      (aw_q == `SSP_ADDR_FLAGS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SSP_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `SSP_RESP_OKAY;
      aw_q          <= 5'h00;
      aw_have_q     <= 1'b0;
      wd_q          <= 32'h0000_0000;
      ws_q          <= 4'h0;
      w_have_q      <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q      <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wd_q     <= s_axi_wdata;
        ws_q     <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end
      if (wr_go) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `SSP_RESP_OKAY : `SSP_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= `SSP_RESP_OKAY;
        case (raddr)
          {1'b0, `SSP_ADDR_STATUS}: s_axi_rdata <= {24'h000000, stat_q};
          {1'b0, `SSP_ADDR_CTRL1}:  s_axi_rdata <= {24'h000000, ctrl1_q};
          {1'b0, `SSP_ADDR_CTRL2}:  s_axi_rdata <= {24'h000000, ctrl2_q};
          {1'b0, `SSP_ADDR_BUFFER}: s_axi_rdata <= {24'h000000, buf_q};
          `SSP_ADDR_FLAGS:          s_axi_rdata <= {31'h00000000, if_q};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `SSP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and shift engine
  wire       done_m  = master && busy_q && m_tick && phase_q && (cnt_q == `SSP_BITS - 4'h1);
  wire       done_s  = s_sample && (cnt_q == `SSP_BITS - 4'h1);
  wire       done    = done_m || done_s;
  // Master reads the data pin directly: the two-flop delay would exceed a half period
  wire       m_last  = cke ? (input_sample_late ? sdi_in : samp_q) : sdi_in;
  wire [7:0] rx_byte = {sr_q[6:0], done_m ? m_last : sdi_s};
  wire [7:0] wsb     = wd_q[7:0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      stat_q     <= `SSP_RESET_BYTE;
      ctrl1_q    <= `SSP_RESET_BYTE;
      ctrl2_q    <= `SSP_RESET_BYTE;
      buf_q      <= `SSP_RESET_BYTE;
      sr_q       <= `SSP_RESET_BYTE;
      if_q       <= 1'b0;
      busy_q     <= 1'b0;
      cnt_q      <= 4'h0;
      div_q      <= 6'h00;
      phase_q    <= 1'b0;
      sclk_q     <= 1'b0;
      samp_q     <= 1'b0;
      sin_q      <= 1'b0;
      sck_prev_q <= 1'b0;
      tmr_prev_q <= 1'b0;
      sclk_out   <= 1'b0;
      sclk_oe    <= 1'b0;
      sdo_out    <= 1'b0;
      sdo_oe     <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
      tmr_prev_q <= timer_tick;
      // Register writes; status low six bits stay hardware-owned
      if (wr_go && ws_q[0]) begin
        if (aw_q == {1'b0, `SSP_ADDR_STATUS})
          stat_q[7:6] <= wsb[7:6];
        if (aw_q == {1'b0, `SSP_ADDR_CTRL1})
          ctrl1_q <= wsb;
        if (aw_q == {1'b0, `SSP_ADDR_CTRL2})
          ctrl2_q <= wsb;
        if (aw_q == `SSP_ADDR_FLAGS && wsb[`SSP_BIT_IF])
          if_q <= 1'b0;
      end
      if (!en)
        stat_q[`SSP_BIT_HALT] <= 1'b0;
      // Disable stops shifting but keeps buffered data
      if (!en) begin
        busy_q  <= 1'b0;
        cnt_q   <= 4'h0;
        phase_q <= 1'b0;
      end
      // Buffer write loads buffer and shifter, or collides
      if (wr_buf && en) begin
        if (busy_q || (slave && cnt_q != 4'h0)) begin
          ctrl1_q[`SSP_BIT_WRITE_COLLISION] <= 1'b1;
        end else begin
          buf_q   <= wsb;
          sr_q    <= wsb;
          sdo_out <= wsb[7];
          busy_q  <= master;
          cnt_q   <= 4'h0;
          phase_q <= 1'b0;
          div_q   <= half_period(mode);
        end
      end
      // Master clock generation, half period per tick
      if (master && busy_q && en) begin
        if (mode != `SSP_MODE_TMR)
          div_q <= (div_q == 6'h00) ? half_period(mode) : div_q - 6'h01;
        if (m_tick) begin
          phase_q <= !phase_q;
          sclk_q  <= !sclk_q;
          if (!phase_q) begin
            // Leading edge; the pin still shows the previous bit here
            if (!cke && cnt_q != 4'h0)
              {sdo_out, sr_q} <= {sr_q[6], sr_q[6:0], input_sample_late ? sdi_in : sin_q};
            samp_q <= sdi_in;
          end else begin
            sin_q <= sdi_in;
            if (cnt_q == `SSP_BITS - 4'h1) begin
              busy_q <= 1'b0;
              cnt_q  <= 4'h0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              if (cke)
                {sdo_out, sr_q} <= {sr_q[6], sr_q[6:0], input_sample_late ? sdi_in : samp_q};
            end
          end
        end
      end else begin
        sclk_q <= clock_idle_level;
      end
      // Slave shifting on the external clock
      if (s_sample) begin
        sr_q <= {sr_q[6:0], sdi_s};
        cnt_q <= (cnt_q == `SSP_BITS - 4'h1) ? 4'h0 : cnt_q + 4'h1;
      end
      if (s_shift && cnt_q != 4'h0)
        sdo_out <= sr_q[7];
      // Completed byte moves to the buffer
      if (done) begin
        buf_q <= rx_byte;
        if (slave && stat_q[`SSP_BIT_BF])
          ctrl1_q[`SSP_BIT_OVF] <= 1'b1;
        else
          stat_q[`SSP_BIT_BF] <= 1'b1;
        if_q <= 1'b1;
      end else if (rd_buf) begin
        stat_q[`SSP_BIT_BF] <= 1'b0;
      end
      // Pin drive, two pins: clock and data out; select is input only
      sclk_out <= master ? (busy_q ? sclk_q : clock_idle_level) : 1'b0;
      sclk_oe  <= en && master;
      sdo_oe   <= en && (master || ss_ok);
    end
  end
endmodule

// ==== tb/ssp_spi_properties.sv ====
`timescale 1ns/1ps
module ssp_spi_props (
  input wire        aclk,
  input wire        aresetn,
  input wire [4:0]  s_axi_awaddr,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        ss_n_in,
  input wire        sclk_out,
  input wire        sclk_oe,
  input wire        sdo_out,
  input wire        sdo_oe
);
  reg  [7:0] ctl_q;
  reg  [4:0] cnt_q;
  reg        busy_q;
  reg        tx7_q;
  wire       wr_go  = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire       master = ctl_q[5] && ctl_q[3:0] < 4'h4;
  ////////////////////////////////////////////////////////////////
  // Shadow of control one and a count of clock edges per byte
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctl_q <= 8'h00;
      cnt_q <= 5'h00;
      busy_q <= 1'b0;
      tx7_q <= 1'b0;
    end else begin
      if (wr_go && s_axi_awaddr == 5'h04) ctl_q <= s_axi_wdata[7:0];
      if (wr_go && s_axi_awaddr == 5'h0c && master && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= 5'h00;
        tx7_q <= s_axi_wdata[7];
      end else if (busy_q && $changed(sclk_out)) begin
        cnt_q <= cnt_q + 5'h01;
        if (cnt_q == 5'h0f) busy_q <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_load;
    wr_go && s_axi_awaddr == 5'h0c && master && !busy_q;
  endsequence
  sequence s_tog;
    busy_q && $changed(sclk_out);
  endsequence
  property p_first_bit;
    s_load |-> ##[1:3] (sdo_oe && sdo_out == tx7_q);
  endproperty
  property p_half4;
    s_tog ##0 (ctl_q[3:0] == 4'h0 && cnt_q < 5'h0f) |=> $stable(sclk_out) ##1 $changed(sclk_out);
  endproperty
  property p_half16;
    s_tog ##0 (ctl_q[3:0] == 4'h1 && cnt_q < 5'h0f) |=> $stable(sclk_out) [*7] ##1 $changed(sclk_out);
  endproperty
  property p_count;
    s_tog ##0 (cnt_q == 5'h0f) |=> (sclk_out == ctl_q[4]) [*8];
  endproperty
  property p_idle;
    (master && !busy_q && $stable(ctl_q)) [*4] |-> sclk_oe && sclk_out == ctl_q[4];
  endproperty
  property p_off;
    (!ctl_q[5]) [*4] |-> !sclk_oe && !sdo_oe;
  endproperty
  property p_slv_sel;
    (ctl_q[5] && ctl_q[3:0] == 4'h4 && ss_n_in) [*5] |-> !sdo_oe && !sclk_oe;
  endproperty
  property p_slv_clk;
    (ctl_q[5] && ctl_q[3:0] == 4'h5) [*4] |-> !sclk_oe;
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("first bit wrong");
  a_half4: assert property (p_half4) else $error("half period wrong");
  a_half16: assert property (p_half16) else $error("half period wrong");
  a_count: assert property (p_count) else $error("extra clock edge");
  a_idle: assert property (p_idle) else $error("clock not idle");
  a_off: assert property (p_off) else $error("pins driven when off");
  a_slv_sel: assert property (p_slv_sel) else $error("output unselected");
  a_slv_clk: assert property (p_slv_clk) else $error("slave drives clock");
endmodule
bind ssp_spi ssp_spi_props u_props (.*);

// ==== tb/ssp_spi_peer.sv ====
`timescale 1ns/1ps
module ssp_spi_peer (
  input  wire       sclk,
  input  wire       mosi,
  input  wire       cpol,
  input  wire       cke,
  input  wire       load,
  input  wire [7:0] tx,
  output reg        miso,
  output reg  [7:0] rx
);
  reg [7:0] sh;
  // Refill with inverted bits so a late sample never sees stale data
  task shift_out;
    begin
      miso = sh[7];
      sh = {sh[6:0], ~sh[7]};
    end
  endtask
  initial begin
    miso = 1'b0;
    rx = 8'h00;
    sh = 8'h00;
  end
  always @(posedge load) begin
    sh = tx;
    if (cke) shift_out;
  end
  always @(sclk) begin
    if ((sclk != cpol) == cke) rx = {rx[6:0], mosi};
    else shift_out;
  end
endmodule

// ==== tb/sync_serial_port_spi_tb.sv ====
`timescale 1ns/1ps
module sync_serial_port_spi_tb;
  reg         aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  reg         s_axi_arvalid = 0, s_axi_rready = 0, timer_tick = 0, sclk_in = 0, ss_n_in = 1;
  reg  [4:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  reg  [31:0] s_axi_wdata = 0;
  reg  [3:0]  s_axi_wstrb = 4'hf;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire        sclk_out, sclk_oe, sdo_out, sdo_oe, sdi_in;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [7:0]  prx;
  reg         ld = 0, cpol = 0, cke = 0;
  reg  [7:0]  ptx = 0, tx, input_sample_late;
  reg  [31:0] d;
  reg  [1:0]  r;
  integer     error_cnt = 0, n_checks = 0, seed = 63153, i, j, k, tc = 0;
  integer     q[$];
  wire        lclk = sclk_oe ? sclk_out : cpol;
  ssp_spi dut (.*);
  ssp_spi_peer peer (.sclk(lclk), .mosi(sdo_out), .cpol(cpol), .cke(cke), .load(ld), .tx(ptx),
                     .miso(sdi_in), .rx(prx));
  always #2.5 aclk = ~aclk;
  always @(posedge aclk) begin
    tc <= tc + 1;
    timer_tick <= tc[3];
  end
  ////////////////////////////////////////////////////////////////
  task test_done;
    begin
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task tmo;
    begin
      error_cnt = error_cnt + 1;
      test_done;
    end
  endtask
  task chk(input [31:0] s, input [31:0] e);
    begin
      n_checks = n_checks + 1;
      if (s !== e) begin
        error_cnt = error_cnt + 1;
        $display("mismatch %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task wr(input [4:0] a, input [7:0] v);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, v};
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (i = 40; i > 0; i = i - 1) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 0;
        if (s_axi_wready) s_axi_wvalid <= 0;
        if (s_axi_bvalid) begin
          r = s_axi_bresp;
          s_axi_bready <= 0;
          i = -1;
        end
      end
      if (i == 0) tmo;
    end
  endtask
  task rd(input [4:0] a, output [31:0] v);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (i = 40; i > 0; i = i - 1) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 0;
        if (s_axi_rvalid) begin
          v = s_axi_rdata;
          r = s_axi_rresp;
          s_axi_rready <= 0;
          i = -1;
        end
      end
      if (i == 0) tmo;
    end
  endtask
  task rc(input [4:0] a, input [31:0] e);
    begin
      rd(a, d);
      chk(d, e);
    end
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    for (k = 0; k < 5; k = k + 1) rc(k * 4, 0);
    rd(5'h14, d);
    chk(r, 2);
    wr(5'h18, 8'h5a);
    chk(r, 2);
    wr(0, 8'hff);
    rc(0, 32'hc0);
    tx = $random(seed) & 8'h1f;
    wr(4, tx);
    rc(4, tx);
    wr(4, 0);
    for (k = 0; k < 4; k = k + 1) begin
      cpol <= k[0];
      cke <= k[1];
      input_sample_late = {k == 2, k[1], 6'h0};
      wr(0, input_sample_late);
      wr(4, {3'h1, k[0], k[3:0]});
      ptx <= $random(seed);
      ld <= 1;
      tx = $random(seed);
      wr(5'h0c, tx);
      q.push_back(ptx);
      ld <= 0;
      wr(5'h0c, ~tx);
      d = 0;
      for (j = 300; j > 0 && d[0] !== 1'b1; j = j - 1) rd(0, d);
      if (j == 0) tmo;
      chk(d, input_sample_late | 8'h01);
      rc(5'h0c, q.pop_front());
      chk(prx, tx);
      rc(0, input_sample_late);
      rc(5'h10, 1);
      wr(5'h10, 8'h01);
      rc(5'h10, 0);
      rc(4, {3'h5, k[0], k[3:0]});
      wr(4, 0);
      rc(4, 0);
    end
    wr(0, 0);
    wr(4, 8'h24);
    repeat (6) @(posedge aclk);
    chk(sdo_oe, 0);
    chk(sclk_oe, 0);
    wr(4, 8'h25);
    repeat (4) @(posedge aclk);
    chk(sclk_oe, 0);
    wr(4, 0);
    repeat (5) @(posedge aclk);
    chk(sdo_oe, 0);
    test_done;
  end
endmodule
